// >>> hw/etp_pkg.sv
// Shared constants and types for the eight-bit timer with shared prescaler.
// Assumes a single 50 MHz system clock, four clocks per instruction cycle.
`default_nettype none

package etp_pkg;

    // Clocking
    localparam int CLK_PERIOD_NS  = 20;
    localparam int INSTR_CLKS     = 4;
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

    // Bus and data widths
    localparam int ETP_DATA_W     = 32;
    localparam int ETP_ADDR_W     = 8;
    localparam int ETP_COUNT_W    = 8;
    localparam int ETP_PRE_W      = 8;

    // Register byte offsets
    localparam logic [7:0] ETP_OFF_COUNT  = 8'h00;
    localparam logic [7:0] ETP_OFF_OPTION = 8'h04;
    localparam logic [7:0] ETP_OFF_INTCTL = 8'h08;
    localparam logic [7:0] ETP_OFF_CTRL   = 8'h0C;

    // Option register fields
    localparam int ETP_OPT_SRC    = 5;
    localparam int ETP_OPT_EDGE   = 4;
    localparam int ETP_OPT_ASSIGN = 3;
    localparam int ETP_OPT_RATE   = 0;
    localparam int ETP_RATE_W     = 3;

    // Interrupt control register fields
    localparam int ETP_INT_EN     = 5;
    localparam int ETP_INT_FLAG   = 2;

    // Control register fields
    localparam int ETP_CTL_WDTCLR = 0;
    localparam int ETP_CTL_SLEEP  = 1;

    // Values after reset, and the count at which overflow occurs
    localparam logic [7:0] ETP_RST_COUNT  = 8'h00;
    localparam logic [7:0] ETP_RST_OPTION = 8'hFF;
    localparam logic [7:0] ETP_MAX_COUNT  = 8'hFF;

    // Internal phase clocks within one instruction cycle
    typedef enum logic [1:0] {
        ETP_Q1,
        ETP_Q2,
        ETP_Q3,
        ETP_Q4
    } etp_phase_t;

    // Complete state of the timer block
    typedef struct packed {
        etp_phase_t       phase;
        logic [7:0]       count;
        logic [7:0]       option;
        logic             ovfFlag;
        logic             ovfIrqEn;
        logic             sleep;
        logic [1:0]       inhibit;
        logic             extPrev;
        logic             pendEdge;
        logic             syncQ2;
        logic             wdtClr;
        logic [7:0]       addr;
        logic             wrPend;
        logic [31:0]      rdata;
    } etp_state_t;

endpackage : etp_pkg

`default_nettype wire

// >>> hw/etp_prescaler.sv
// Shared ripple prescaler: divides a tick stream by a power of two.
// Assumes tick and clear are single-cycle strobes from the timer core.
`default_nettype none

module etp_prescaler #(
    parameter int WIDTH = etp_pkg::ETP_PRE_W
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          tick,
    input  wire logic                          clear,
    input  wire logic                          toWdt,
    input  wire logic [etp_pkg::ETP_RATE_W-1:0] rate,
    output logic                               pulse
);
    import etp_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             pulse;
    } etp_pre_state_t;

    etp_pre_state_t st;
    etp_pre_state_t nx;

    // Ratio 1:256 needs eight counter bits
    if (WIDTH < 8) begin : g_width_check
        $error("etp_prescaler WIDTH must be at least 8");
    end

    // True when the low k bits of v are all ones
    function automatic logic lowOnes(input logic [WIDTH-1:0] v, input int k);
        logic r;
        r = 1'b1;
        for (int i = 0; i < WIDTH; i++) begin
            if (i < k && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    // Count ticks, emit a pulse at the end of each divided period
    always_comb begin
        nx       = st;
        nx.pulse = 1'b0;
        if (clear) begin
            nx.cnt = '0;
        end else if (tick) begin
            nx.cnt = WIDTH'(st.cnt + 1'b1);
            if (toWdt) begin
                nx.pulse = lowOnes(st.cnt, int'(rate));
            end else begin
                nx.pulse = lowOnes(st.cnt, int'(rate) + 1);
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign pulse = st.pulse;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_pre_clear;
        clear |=> (st.cnt == '0);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

    property p_pre_half;
        (tick && !clear && !toWdt && rate == 3'h0 && st.cnt[0]) |=> pulse;
    endproperty
    a_pre_half: assert property (p_pre_half) else $error("1:2 ratio pulse missing");

    property p_pre_timer_no_bypass;
        (tick && !clear && !toWdt && !st.cnt[0]) |=> !pulse;
    endproperty
    a_pre_timer_no_bypass: assert property (p_pre_timer_no_bypass) else $error("timer ratio below 1:2");

    c_pre_full: cover property (tick && !toWdt && rate == 3'h7 && st.cnt == 8'hFF);

endmodule : etp_prescaler

`default_nettype wire

// >>> hw/etp_timer.sv
// Eight-bit timer/counter with shared prescaler, AHB-Lite register slave.
// Assumes synchronous pin inputs and a watchdog that supplies its base tick.
`default_nettype none

module etp_timer (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          hsel,
    input  wire logic [etp_pkg::ETP_DATA_W-1:0] haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [etp_pkg::ETP_DATA_W-1:0] hwdata,
    input  wire logic                          hready,
    output logic      [etp_pkg::ETP_DATA_W-1:0] hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic                          extCountPin,
    input  wire logic                          wdtTick,
    output logic                               wdtTickOut,
    output logic                               wdtClear,
    output logic                               irqRequest
);
    import etp_pkg::*;

    etp_state_t st;
    etp_state_t nx;

    logic       instrTick;
    logic       toWdt;
    logic       srcExt;
    logic       wrCount;
    logic       wrOption;
    logic       wrIntctl;
    logic       wrCtrl;
    logic       wrWdtClr;
    logic       edgeRaw;
    logic       srcTick;
    logic       preTick;
    logic       preClear;
    logic       prePulse;
    logic       countEv;
    logic       incNow;
    logic       ovfSet;
    logic       addrPhase;

    // Register read mux over a candidate state
    function automatic logic [31:0] readReg(input logic [7:0] a, input etp_state_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            ETP_OFF_COUNT:  r[7:0] = s.count;
            ETP_OFF_OPTION: r[7:0] = s.option;
            ETP_OFF_INTCTL: begin
                r[ETP_INT_EN]   = s.ovfIrqEn;
                r[ETP_INT_FLAG] = s.ovfFlag;
            end
            ETP_OFF_CTRL:   r[ETP_CTL_SLEEP] = s.sleep;
            default:        r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Shared prescaler
    etp_prescaler #(
        .WIDTH (ETP_PRE_W)
    ) u_pre (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (preTick),
        .clear (preClear),
        .toWdt (toWdt),
        .rate  (st.option[ETP_OPT_RATE +: ETP_RATE_W]),
        .pulse (prePulse)
    );

    // Next-state logic for phase, counting, flags and bus
    always_comb begin
        nx = st;

        // Four phase clocks make one instruction cycle
        case (st.phase)
            ETP_Q1:  nx.phase = ETP_Q2;
            ETP_Q2:  nx.phase = ETP_Q3;
            ETP_Q3:  nx.phase = ETP_Q4;
            default: nx.phase = ETP_Q1;
        endcase
        instrTick = (st.phase == ETP_Q4);

        // Mode decode
        toWdt  = st.option[ETP_OPT_ASSIGN];
        srcExt = st.option[ETP_OPT_SRC];

        // Data-phase write strobes
        wrCount  = st.wrPend && (st.addr == ETP_OFF_COUNT);
        wrOption = st.wrPend && (st.addr == ETP_OFF_OPTION);
        wrIntctl = st.wrPend && (st.addr == ETP_OFF_INTCTL);
        wrCtrl   = st.wrPend && (st.addr == ETP_OFF_CTRL);
        wrWdtClr = wrCtrl && hwdata[ETP_CTL_WDTCLR];

        // Edge detection on the external count pin
        if (st.option[ETP_OPT_EDGE]) begin
            edgeRaw = st.extPrev && !extCountPin;
        end else begin
            edgeRaw = !st.extPrev && extCountPin;
        end
        nx.extPrev = extCountPin;

        // Source selection and prescaler routing
        srcTick  = srcExt ? edgeRaw : instrTick;
        preTick  = toWdt ? wdtTick : (srcTick && !st.sleep);
        preClear = (wrCount && !toWdt) || (wrWdtClr && toWdt);
        countEv  = (toWdt ? srcTick : prePulse) && !st.sleep;

        // Two-stage capture of external events on Q2 then Q4
        if (srcExt) begin
            nx.pendEdge = countEv || (st.pendEdge && st.phase != ETP_Q2);
            if (st.phase == ETP_Q2) begin
                nx.syncQ2 = st.pendEdge;
            end else if (st.phase == ETP_Q4) begin
                nx.syncQ2 = 1'b0;
            end
        end else begin
            nx.pendEdge = 1'b0;
            nx.syncQ2   = 1'b0;
        end

        // Increment, gated by sleep and the write inhibit window
        incNow = !st.sleep && (st.inhibit == 2'h0) &&
                 (srcExt ? (st.phase == ETP_Q4 && st.syncQ2) : countEv);
        ovfSet = incNow && (st.count == ETP_MAX_COUNT);
        if (instrTick && st.inhibit != 2'h0) begin
            nx.inhibit = st.inhibit - 2'h1;
        end
        if (incNow) begin
            nx.count = st.count + 8'h01;
        end

        // Register writes
        if (wrCount) begin
            nx.count   = hwdata[7:0];
            nx.inhibit = INHIBIT_CYCLES;
        end
        if (wrOption) begin
            nx.option = hwdata[7:0];
        end
        if (wrIntctl) begin
            nx.ovfIrqEn = hwdata[ETP_INT_EN];
        end
        nx.ovfFlag = ovfSet || (wrIntctl ? hwdata[ETP_INT_FLAG] : st.ovfFlag);
        if (wrCtrl) begin
            nx.sleep = hwdata[ETP_CTL_SLEEP];
        end
        nx.wdtClr = wrWdtClr;

        // AHB-Lite address phase capture
        addrPhase = hsel && hready && htrans[1];
        nx.wrPend = 1'b0;
        if (addrPhase) begin
            nx.addr   = haddr[ETP_ADDR_W-1:0];
            nx.wrPend = hwrite;
            if (!hwrite) begin
                nx.rdata = readReg(haddr[ETP_ADDR_W-1:0], nx);
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st        <= '0;
            st.phase  <= ETP_Q1;
            st.count  <= ETP_RST_COUNT;
            st.option <= ETP_RST_OPTION;
        end else begin
            st <= nx;
        end
    end

    // Outputs
    assign hrdata     = st.rdata;
    assign hreadyout  = 1'b1;              // Zero wait states
    assign hresp      = 1'b0;              // Always OKAY
    assign wdtTickOut = toWdt ? prePulse : wdtTick;
    assign wdtClear   = st.wdtClr;
    assign irqRequest = st.ovfFlag && st.ovfIrqEn;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_timer_inc;
        (!srcExt && toWdt && !st.sleep && st.inhibit == 2'h0 && instrTick && !wrCount)
            |=> (st.count == $past(st.count) + 8'h01);
    endproperty
    a_timer_inc: assert property (p_timer_inc) else $error("timer missed instruction-cycle increment");

    property p_inhibit_load;
        wrCount |=> (st.inhibit == 2'h2) ##1 (st.count == $past(st.count));
    endproperty
    a_inhibit_load: assert property (p_inhibit_load) else $error("write did not start inhibit");

    property p_inhibit_hold;
        (st.inhibit != 2'h0 && !wrCount) |=> (st.count == $past(st.count));
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved during inhibit");

    property p_fall_edge;
        (srcExt && toWdt && !st.sleep && st.option[ETP_OPT_EDGE] && st.extPrev && !extCountPin)
            |=> st.pendEdge;
    endproperty
    a_fall_edge: assert property (p_fall_edge) else $error("falling edge not captured");

    property p_ext_q4_only;
        (srcExt && !wrCount && st.phase != ETP_Q4) |=> (st.count == $past(st.count));
    endproperty
    a_ext_q4_only: assert property (p_ext_q4_only) else $error("counter mode moved off Q4");

    property p_count_write_clr;
        (wrCount && !toWdt) |=> (u_pre.st.cnt == 8'h00);
    endproperty
    a_count_write_clr: assert property (p_count_write_clr) else $error("prescaler kept on count write");

    property p_wdt_clr;
        (wrWdtClr && toWdt) |=> (u_pre.st.cnt == 8'h00) && wdtClear;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog clear missed prescaler");

    property p_overflow;
        (incNow && !wrCount && st.count == 8'hFF) |=> (st.count == 8'h00) && st.ovfFlag;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_flag_sticky;
        (st.ovfFlag && !wrIntctl) |=> st.ovfFlag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

    property p_sleep_freeze;
        (st.sleep && !wrCount && !wrIntctl) |=> $stable(st.count) && !$rose(st.ovfFlag);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("timer ran in sleep");

    property p_irq;
        ($rose(st.ovfFlag) && st.ovfIrqEn) |-> irqRequest ##1 (irqRequest || !st.ovfFlag || !st.ovfIrqEn);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request not raised");

    property p_q4_wrap;
        (st.phase == ETP_Q4) |=> (st.phase == ETP_Q1);
    endproperty
    a_q4_wrap: assert property (p_q4_wrap) else $error("instruction cycle not four clocks");

    property p_irq_gate;
        !st.ovfIrqEn |-> !irqRequest;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request raised while disabled");

    property p_flag_no_enable;
        (ovfSet && !st.ovfIrqEn) |=> st.ovfFlag;
    endproperty
    a_flag_no_enable: assert property (p_flag_no_enable) else $error("flag needs enable");

    property p_rise_edge;
        (srcExt && toWdt && !st.sleep && !st.option[ETP_OPT_EDGE] && !st.extPrev && extCountPin) |=> st.pendEdge;
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising edge not captured");

    property p_wdt_route;
        !toWdt |-> (wdtTickOut == wdtTick);
    endproperty
    a_wdt_route: assert property (p_wdt_route) else $error("watchdog tick divided by timer prescaler");

    property p_pre_hold;
        (!toWdt && !srcExt && !prePulse && !wrCount) |=> $stable(st.count);
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("timer counted undivided");

    c_overflow:    cover property (ovfSet && st.ovfIrqEn);
    c_ext_count:   cover property (srcExt && incNow);
    c_inhibit:     cover property (wrCount ##1 (instrTick && st.inhibit == 2'h2));
    c_wdt_clear:   cover property (wrWdtClr && toWdt);

endmodule : etp_timer

`default_nettype wire

// >>> tb/etp_pulse_src.sv
// Pulse source model standing on the external count pin.
// Assumes the bench calls its tasks just after a rising clock edge.
`default_nettype none

module etp_pulse_src (
    input  wire logic clk,
    output var  logic pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pin idles low between bursts
    initial pin = 1'b0;

    // Drive a level and keep it for a number of clocks
    task automatic hold(input logic lvl, input int clks);
        pin <= lvl;
        repeat (clks) @(posedge clk);
    endtask

    // Whole pulses, each half two instruction cycles long
    task automatic burst(input int n);
        repeat (n) begin
            hold(1'b1, 8);
            hold(1'b0, 8);
        end
    endtask
endmodule // etp_pulse_src

`default_nettype wire

// >>> tb/test_eight_bit_timer_prescaler.sv
// Self-checking bench for the eight-bit timer with shared prescaler.
// Assumes the zero-wait register slave and the pulse source model beside it.
`default_nettype none

module test_eight_bit_timer_prescaler;
    import etp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rst_b, hsel, hwrite, wdtTick, hreadyout, hresp;
    logic        extCountPin, wdtTickOut, wdtClear, irqRequest;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          err_total = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          outCnt = 0;
    int          clrCnt = 0;

    etp_timer u_etp_timer (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .extCountPin(extCountPin), .wdtTick(wdtTick), .wdtTickOut(wdtTickOut),
        .wdtClear(wdtClear), .irqRequest(irqRequest)
    );

    etp_pulse_src u_etp_pulse_src (
        .clk(clk),
        .pin(extCountPin)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulse counters and hang limit
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wdtTickOut === 1'b1) outCnt <= outCnt + 1;
        if (wdtClear === 1'b1) clrCnt <= clrCnt + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, off};
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // Read and compare
    task automatic rdc(input logic [7:0] off, input logic [31:0] exp);
        bus(1'b0, off, 32'h0);
        check(rd, exp);
    endtask

    task automatic t_reset();
        rdc(ETP_OFF_COUNT, 32'h00);
        rdc(ETP_OFF_OPTION, 32'hFF);
        rdc(ETP_OFF_INTCTL, 32'h00);
        rdc(ETP_OFF_CTRL, 32'h00);
        rdc(8'h10, 32'h00);
        check({31'h0, hresp}, 32'h0);
        check({31'h0, hreadyout}, 32'h1);
    endtask

    task automatic t_timer();
        bus(1'b1, ETP_OFF_OPTION, 32'h0F);
        bus(1'b1, ETP_OFF_COUNT, 32'h10);
        repeat (16) @(posedge clk);
        rdc(ETP_OFF_COUNT, 32'h12);
        repeat (38) @(posedge clk);
        rdc(ETP_OFF_COUNT, 32'h1C);
    endtask

    task automatic t_ovf();
        bus(1'b1, ETP_OFF_INTCTL, 32'h00);
        bus(1'b1, ETP_OFF_COUNT, 32'hFF);
        repeat (12) @(posedge clk);
        rdc(ETP_OFF_COUNT, 32'h00);
        rdc(ETP_OFF_INTCTL, 32'h04);
        check({31'h0, irqRequest}, 32'h0);
        repeat (100) @(posedge clk);
        rdc(ETP_OFF_INTCTL, 32'h04);
        bus(1'b1, ETP_OFF_INTCTL, 32'h24);
        @(posedge clk);
        check({31'h0, irqRequest}, 32'h1);
        bus(1'b1, ETP_OFF_INTCTL, 32'h20);
        @(posedge clk);
        check({31'h0, irqRequest}, 32'h0);
    endtask

    task automatic t_presc();
        int          p;
        logic [31:0] c0;
        for (int r = 0; r < 8; r++) begin
            p = 8 << r;
            bus(1'b1, ETP_OFF_OPTION, 32'(r));
            bus(1'b1, ETP_OFF_COUNT, 32'h00);
            repeat (16) @(posedge clk);
            bus(1'b0, ETP_OFF_COUNT, 32'h0);
            c0 = rd;
            repeat (2 * p - 2) @(posedge clk);
            rdc(ETP_OFF_COUNT, c0 + 32'h2);
        end
        // A count write must restart the 1:256 division
        bus(1'b1, ETP_OFF_COUNT, 32'h00);
        repeat (600) @(posedge clk);
        bus(1'b1, ETP_OFF_COUNT, 32'h50);
        repeat (600) @(posedge clk);
        rdc(ETP_OFF_COUNT, 32'h50);
    endtask

    task automatic t_count();
        logic [31:0] c0;
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, ETP_OFF_OPTION, 32'h28 | 32'(e << 4));
            bus(1'b1, ETP_OFF_COUNT, 32'h00);
            u_etp_pulse_src.hold(1'b0, 16);
            bus(1'b0, ETP_OFF_COUNT, 32'h0);
            c0 = rd;
            u_etp_pulse_src.hold(1'b1, 12);
            rdc(ETP_OFF_COUNT, c0 + 32'(e == 0));
            u_etp_pulse_src.hold(1'b0, 12);
            rdc(ETP_OFF_COUNT, c0 + 32'h1);
            u_etp_pulse_src.burst(5);
            repeat (12) @(posedge clk);
            rdc(ETP_OFF_COUNT, c0 + 32'h6);
        end
    endtask

    // Counter mode through the 1:2 prescaler: two rising edges per count
    task automatic t_count_pre();
        bus(1'b1, ETP_OFF_OPTION, 32'h20);
        bus(1'b1, ETP_OFF_COUNT, 32'h00);
        u_etp_pulse_src.hold(1'b0, 16);
        u_etp_pulse_src.burst(6);
        repeat (12) @(posedge clk);
        rdc(ETP_OFF_COUNT, 32'h03);
    endtask

    task automatic t_sleep();
        bus(1'b1, ETP_OFF_OPTION, 32'h08);
        bus(1'b1, ETP_OFF_INTCTL, 32'h00);
        bus(1'b1, ETP_OFF_COUNT, 32'hFF);
        bus(1'b1, ETP_OFF_CTRL, 32'h02);
        repeat (40) @(posedge clk);
        rdc(ETP_OFF_COUNT, 32'hFF);
        rdc(ETP_OFF_INTCTL, 32'h00);
        rdc(ETP_OFF_CTRL, 32'h02);
        bus(1'b1, ETP_OFF_CTRL, 32'h00);
    endtask

    // Eight watchdog base ticks, then count what came out
    task automatic ticks(input logic [31:0] exp);
        int o0;
        o0 = outCnt;
        repeat (8) begin
            wdtTick <= 1'b1;
            @(posedge clk);
            wdtTick <= 1'b0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        check(32'(outCnt - o0), exp);
    endtask

    task automatic t_wdt();
        int n0;
        n0 = clrCnt;
        bus(1'b1, ETP_OFF_CTRL, 32'h01);
        bus(1'b1, ETP_OFF_COUNT, 32'h00);
        bus(1'b1, ETP_OFF_OPTION, 32'h08);
        bus(1'b1, ETP_OFF_CTRL, 32'h01);
        bus(1'b1, ETP_OFF_OPTION, 32'h0A);
        repeat (3) @(posedge clk);
        check(32'(clrCnt - n0), 32'h2);
        ticks(32'h2);
        bus(1'b1, ETP_OFF_CTRL, 32'h01);
        bus(1'b1, ETP_OFF_OPTION, 32'h02);
        ticks(32'h8);
    endtask

    // Counts and verdict, then stop
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        wdtTick = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_timer();
        t_ovf();
        t_presc();
        t_count();
        t_count_pre();
        t_sleep();
        t_wdt();
        print_verdict();
    end
endmodule // test_eight_bit_timer_prescaler

`default_nettype wire
